// ===== hbpw_assertions.sv
// checker for the parallel bus between the host end and the device end
// assumes the testbench instantiates it beside the bus interface
`default_nettype none
module hbpw_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ad_host_oe,
  input wire logic [7:0] ad_dev,
  input wire logic ad_dev_oe,
  input wire logic ale,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_one_n
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // bus cycle steps
  // ----------------------------------------------------------------
  sequence s_addr_phase;
    ale [*4] ##1 !ale;
  endsequence
  sequence s_strobe8;
    !read_strobe_n [*8] ##1 read_strobe_n;
  endsequence

  property p_no_fight;
    !(ad_dev_oe && ad_host_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_idle_release;
    read_strobe_n [*6] |-> !ad_dev_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("device holds bus");
  property p_read_drive;
    $fell(read_strobe_n) && !chip_select_one_n && write_strobe_n |-> ##[1:7] ad_dev_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not answered");
  property p_write_quiet;
    !write_strobe_n [*4] |-> !ad_dev_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("device drives in write");
  property p_strobe_len;
    $fell(read_strobe_n) |-> s_strobe8;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("read strobe length");
  property p_mux_order;
    $rose(ale) && !chip_select_one_n |-> s_addr_phase ##4 (!read_strobe_n || !write_strobe_n);
  endproperty
  a_mux_order: assert property (p_mux_order) else $error("mux address phase order");
  property p_cs_release;
    $rose(chip_select_one_n) |-> read_strobe_n && $past(read_strobe_n);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("select dropped in strobe");
  property p_dev_stable;
    ad_dev_oe && $past(ad_dev_oe) && !read_strobe_n |-> $stable(ad_dev);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("read data moved");
endmodule : hbpw_assertions
`default_nettype wire

// ===== hbpw_bus_if.sv
// parallel host bus between the host controller and the device
// assumes the testbench instantiates it and ties both ends to it
`default_nettype none
interface hbpw_bus_if;
  logic [7:0] ad_host;
  logic ad_host_oe;
  logic [7:0] ad_dev;
  logic ad_dev_oe;
  logic [7:0] ad;
  logic [7:0] addr;
  logic ale;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chip_select_one_n;

  // resolved level of the shared data lines; idle bus reads zero
  assign ad = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 8'h00);

  modport dev (
    input ad, addr, ale, read_strobe_n, write_strobe_n, chip_select_one_n,
    output ad_dev, ad_dev_oe
  );
  modport host (
    input ad,
    output ad_host, ad_host_oe, addr, ale, read_strobe_n, write_strobe_n,
    chip_select_one_n
  );
endinterface : hbpw_bus_if
`default_nettype wire

// ===== hbpw_device.sv
// device end: bus slave, general ports and frame-sync watchdog
// assumes all bus pins, frame sync and data clock are asynchronous
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
module hbpw_device #(
  parameter int WD_PERIOD = hbpw_pkg::WD_PERIOD_FS,
  parameter int RST_IND_LEN = hbpw_pkg::RESET_IND_FS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_sync_clock_i,
  input wire logic data_clock_in_i,
  input wire logic [3:0] port_in_i,
  output logic [3:0] port_out_o,
  output logic [3:0] port_oe_o,
  output logic watchdog_irq_o,
  output logic reset_indicate_out_o,
  output logic [1:0] bus_style_o,
  hbpw_bus_if.dev bus
);
  typedef enum logic {SVC_IDLE, SVC_ARMED} hbpw_svc_type;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 26;
  // strobes and select rest high, so a reset shows no bus cycle
  localparam logic [SW-1:0] SYNC_IDLE = 26'h00001c0;
  logic [SW-1:0] raw, sync1_ff, sync2_ff, prev_ff;
  assign raw = {bus.ad, bus.addr, bus.ale, bus.read_strobe_n, bus.write_strobe_n,
                bus.chip_select_one_n, frame_sync_clock_i, data_clock_in_i, port_in_i};
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
      prev_ff <= SYNC_IDLE;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  logic [7:0] s_ad, s_addr;
  logic s_ale, s_rs_n, s_ws_n, s_cs_n, s_fs, s_dc, p_ale, p_fs, p_dc;
  logic [3:0] s_port;
  assign {s_ad, s_addr, s_ale, s_rs_n, s_ws_n, s_cs_n, s_fs, s_dc, s_port} = sync2_ff;
  assign p_ale = prev_ff[9];
  assign p_fs = prev_ff[5];
  assign p_dc = prev_ff[4];

  // ----------------------------------------------------------------
  // bus style and address
  // ----------------------------------------------------------------
  logic ale_seen_ff;
  logic [7:0] alatch_ff;
  logic mux_mode;
  hbpw_pkg::hbpw_style_type style;
  logic even_sel_ff;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ale_seen_ff <= 1'b0;
      alatch_ff <= 8'h00;
    end else begin
      // only an address phase inside a selected cycle marks the mux style
      if (p_ale && !s_ale && !s_cs_n) ale_seen_ff <= 1'b1;
      if (p_ale && !s_ale) alatch_ff <= s_ad;
    end
  end

  assign mux_mode = ale_seen_ff;
  assign style = mux_mode ? hbpw_pkg::HBPW_SEP_MUX :
                 (s_ale ? hbpw_pkg::HBPW_STROBE_DIR : hbpw_pkg::HBPW_SEP_DEMUX);

  always_ff @(posedge mclk_i) begin
    if (rst_i) bus_style_o <= 2'(hbpw_pkg::HBPW_SEP_DEMUX);
    else bus_style_o <= 2'(style);
  end

  function automatic logic [7:0] dec_idx(input logic [7:0] a, input logic mux,
                                         input logic even);
    if (mux && !even) dec_idx = {1'b0, a[7:1]};
    else dec_idx = a;
  endfunction : dec_idx

  logic [7:0] idx;
  logic rd_act, wr_act, rd_prev_ff, wr_prev_ff;
  assign idx = dec_idx(mux_mode ? alatch_ff : s_addr, mux_mode, even_sel_ff);
  assign rd_act = !s_cs_n && !s_rs_n && (style != hbpw_pkg::HBPW_STROBE_DIR || s_ws_n);
  assign wr_act = !s_cs_n && (style == hbpw_pkg::HBPW_STROBE_DIR ? (!s_rs_n && !s_ws_n)
                                                                : !s_ws_n);

  // ----------------------------------------------------------------
  // write capture: data and index sampled while the strobe is active, held after it ends
  // ----------------------------------------------------------------
  logic [7:0] wdata_ff, widx_ff;
  logic wr_evt;
  assign wr_evt = wr_prev_ff && !wr_act;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
      wdata_ff <= 8'h00;
      widx_ff <= 8'h00;
    end else begin
      rd_prev_ff <= rd_act;
      wr_prev_ff <= wr_act;
      if (wr_act) begin
        wdata_ff <= s_ad;
        widx_ff <= idx;
      end
    end
  end

  function automatic logic is_wr(input logic ev, input logic [7:0] i, input logic [7:0] r);
    is_wr = ev && i == r;
  endfunction : is_wr

  // ----------------------------------------------------------------
  // general port and mode register
  // ----------------------------------------------------------------
  logic [3:0] dir_ff, val_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dir_ff <= hbpw_pkg::PORT_DIR_RST;
      even_sel_ff <= hbpw_pkg::EVEN_SEL_RST;
    end else begin
      if (is_wr(wr_evt, widx_ff, hbpw_pkg::REG_PORT_DIR)) dir_ff <= wdata_ff[3:0];
      if (is_wr(wr_evt, widx_ff, hbpw_pkg::REG_EXT_MODE)) begin
        even_sel_ff <= wdata_ff[hbpw_pkg::EXT_EVEN_SEL_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      val_ff <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (!dir_ff[b]) val_ff[b] <= s_port[b];
        else if (is_wr(wr_evt, widx_ff, hbpw_pkg::REG_PORT_VAL)) val_ff[b] <= wdata_ff[b];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      port_out_o <= 4'h0;
      port_oe_o <= 4'h0;
    end else begin
      port_out_o <= val_ff;
      port_oe_o <= dir_ff;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic wd_en_ff, ovf_ff, ovf_evt, restart, tick, dc_run;
  logic [7:0] dc_idle_ff;
  logic [9:0] wd_cnt_ff;
  logic [3:0] ri_cnt_ff;
  hbpw_svc_type svc_ff;
  logic wd_wr, s1, s2;

  assign dc_run = dc_idle_ff < 8'(hbpw_pkg::DCLK_TMO_CYC);
  assign tick = s_fs && !p_fs && dc_run;
  assign wd_wr = is_wr(wr_evt, widx_ff, hbpw_pkg::REG_WD_CTRL);
  assign s1 = wdata_ff[hbpw_pkg::WD_SVC1_BIT];
  assign s2 = wdata_ff[hbpw_pkg::WD_SVC2_BIT];
  assign restart = wd_wr && svc_ff == SVC_ARMED && !s1 && s2;
  assign ovf_evt = wd_en_ff && tick && !restart && wd_cnt_ff == 10'(WD_PERIOD - 1);

  always_ff @(posedge mclk_i) begin
    if (rst_i) dc_idle_ff <= 8'(hbpw_pkg::DCLK_TMO_CYC);
    else if (s_dc != p_dc) dc_idle_ff <= 8'h00;
    else if (dc_run) dc_idle_ff <= dc_idle_ff + 8'h01;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) wd_en_ff <= 1'b0;
    else if (wd_wr && wdata_ff[hbpw_pkg::WD_START_BIT]) wd_en_ff <= 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || ovf_evt) svc_ff <= SVC_IDLE;
    else if (wd_wr && s1 && !s2) svc_ff <= SVC_ARMED;
    else if (wd_wr && (s1 || s2)) svc_ff <= SVC_IDLE;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !wd_en_ff || restart || ovf_evt) wd_cnt_ff <= 10'h000;
    else if (tick) wd_cnt_ff <= wd_cnt_ff + 10'h001;
  end

  // overflow flag is cleared by writing one to it; a new overflow wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) ovf_ff <= 1'b0;
    else if (ovf_evt) ovf_ff <= 1'b1;
    else if (is_wr(wr_evt, widx_ff, hbpw_pkg::REG_WD_STAT) && wdata_ff[0]) ovf_ff <= 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ri_cnt_ff <= 4'h0;
      reset_indicate_out_o <= 1'b0;
      watchdog_irq_o <= 1'b0;
    end else begin
      watchdog_irq_o <= ovf_ff || ovf_evt;
      if (ovf_evt) begin
        ri_cnt_ff <= 4'(RST_IND_LEN);
        reset_indicate_out_o <= 1'b1;
      end else if (tick && ri_cnt_ff != 4'h0) begin
        ri_cnt_ff <= ri_cnt_ff - 4'h1;
        if (ri_cnt_ff == 4'h1) reset_indicate_out_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path: data driven on all eight data lines while the read strobe lasts
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic oe_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else if (rd_act && !rd_prev_ff) begin
      oe_ff <= 1'b1;
      case (idx)
        hbpw_pkg::REG_PORT_DIR: rdata_ff <= {4'h0, dir_ff};
        hbpw_pkg::REG_PORT_VAL: rdata_ff <= {4'h0, val_ff};
        hbpw_pkg::REG_IN_PORT: rdata_ff <= mux_mode ? s_addr : 8'h00;
        hbpw_pkg::REG_EXT_MODE: rdata_ff <= {7'h00, even_sel_ff};
        hbpw_pkg::REG_WD_STAT: rdata_ff <= {6'h00, wd_en_ff, ovf_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else if (!rd_act) begin
      oe_ff <= 1'b0;
    end
  end

  assign bus.ad_dev = rdata_ff;
  assign bus.ad_dev_oe = oe_ff;
endmodule : hbpw_device
`default_nettype wire

// ===== hbpw_host.sv
// host end: runs one bus cycle per command from its own registers
// assumes software obeys the service write spacing on the device side
`default_nettype none
module hbpw_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  hbpw_bus_if.host bus
);
  typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_STRB, H_GAP} hbpw_hst_type;

  hbpw_hst_type state_ff;
  logic [1:0] style_ff;
  logic [7:0] taddr_ff;
  logic [7:0] twdata_ff;
  logic [7:0] rdata_ff;
  logic is_read_ff;
  logic [3:0] cnt_ff;
  logic ale_ff, rd_n_ff, wr_n_ff, cs_n_ff, oe_ff;
  logic [7:0] addr_ff, ad_ff;
  logic start;

  assign start = reg_wr_i && reg_addr_i == hbpw_pkg::HREG_CMD && state_ff == H_IDLE;
  assign bus.ale = ale_ff;
  assign bus.read_strobe_n = rd_n_ff;
  assign bus.write_strobe_n = wr_n_ff;
  assign bus.chip_select_one_n = cs_n_ff;
  assign bus.addr = addr_ff;
  assign bus.ad_host = ad_ff;
  assign bus.ad_host_oe = oe_ff;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      style_ff <= 2'h0;
      taddr_ff <= 8'h00;
      twdata_ff <= 8'h00;
      is_read_ff <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == hbpw_pkg::HREG_CTRL) style_ff <= reg_wdata_i[1:0];
      if (reg_addr_i == hbpw_pkg::HREG_ADDR) taddr_ff <= reg_wdata_i;
      if (reg_addr_i == hbpw_pkg::HREG_WDATA) twdata_ff <= reg_wdata_i;
      if (start) is_read_ff <= reg_wdata_i[hbpw_pkg::CMD_READ_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        hbpw_pkg::HREG_CTRL: reg_rdata_o <= {6'h00, style_ff};
        hbpw_pkg::HREG_ADDR: reg_rdata_o <= taddr_ff;
        hbpw_pkg::HREG_WDATA: reg_rdata_o <= twdata_ff;
        hbpw_pkg::HREG_STAT: reg_rdata_o <= {7'h00, state_ff != H_IDLE};
        hbpw_pkg::HREG_RDATA: reg_rdata_o <= rdata_ff;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= H_IDLE;
      cnt_ff <= 4'h0;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      addr_ff <= 8'h00;
      ad_ff <= 8'h00;
      oe_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      case (state_ff)
        H_IDLE: begin
          // static ale level selects the style; mux style toggles it
          ale_ff <= style_ff == hbpw_pkg::HBPW_STROBE_DIR;
          rd_n_ff <= 1'b1;
          wr_n_ff <= 1'b1;
          cs_n_ff <= 1'b1;
          if (start) begin
            cnt_ff <= 4'(hbpw_pkg::HOST_SETUP_CYC);
            cs_n_ff <= 1'b0;
            if (style_ff == hbpw_pkg::HBPW_SEP_MUX) begin
              ale_ff <= 1'b1;
              ad_ff <= taddr_ff;
              oe_ff <= 1'b1;
              state_ff <= H_ALE;
            end else begin
              addr_ff <= taddr_ff;
              state_ff <= H_SETUP;
            end
            if (style_ff == hbpw_pkg::HBPW_STROBE_DIR) wr_n_ff <= reg_wdata_i[0];
          end
        end
        H_ALE: begin
          if (cnt_ff == 4'h1) begin
            ale_ff <= 1'b0;
            cnt_ff <= 4'(hbpw_pkg::HOST_SETUP_CYC);
            state_ff <= H_SETUP;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        H_SETUP: begin
          if (cnt_ff == 4'h1) begin
            cnt_ff <= 4'(hbpw_pkg::HOST_STRB_CYC);
            state_ff <= H_STRB;
            ad_ff <= twdata_ff;
            oe_ff <= !is_read_ff;
            if (is_read_ff || style_ff == hbpw_pkg::HBPW_STROBE_DIR) rd_n_ff <= 1'b0;
            else wr_n_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        H_STRB: begin
          if (cnt_ff == 4'h1) begin
            rdata_ff <= bus.ad;
            rd_n_ff <= 1'b1;
            if (style_ff != hbpw_pkg::HBPW_STROBE_DIR) wr_n_ff <= 1'b1;
            cnt_ff <= 4'(hbpw_pkg::HOST_GAP_CYC);
            state_ff <= H_GAP;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        H_GAP: begin
          oe_ff <= 1'b0;
          cs_n_ff <= 1'b1;
          wr_n_ff <= 1'b1;
          if (cnt_ff == 4'h1) state_ff <= H_IDLE;
          else cnt_ff <= cnt_ff - 4'h1;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end
endmodule : hbpw_host
`default_nettype wire

// ===== hbpw_pkg.sv
// constants shared by both ends of the host bus port and watchdog block
// assumes a single 25 mhz clock on both ends
`default_nettype none
package hbpw_pkg;
  typedef enum logic [1:0] {
    HBPW_STROBE_DIR,
    HBPW_SEP_DEMUX,
    HBPW_SEP_MUX
  } hbpw_style_type;

  // ----------------------------------------------------------------
  // device register indexes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PORT_DIR = 8'h00;
  localparam logic [7:0] REG_PORT_VAL = 8'h01;
  localparam logic [7:0] REG_IN_PORT = 8'h02;
  localparam logic [7:0] REG_WD_CTRL = 8'h03;
  localparam logic [7:0] REG_EXT_MODE = 8'h04;
  localparam logic [7:0] REG_WD_STAT = 8'h05;
  localparam int WD_START_BIT = 0;
  localparam int WD_SVC1_BIT = 1;
  localparam int WD_SVC2_BIT = 2;
  localparam int EXT_EVEN_SEL_BIT = 0;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_EN_BIT = 1;
  localparam logic [3:0] PORT_DIR_RST = 4'h0;
  localparam logic EVEN_SEL_RST = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int WD_PERIOD_FS = 1024;
  localparam int RESET_IND_FS = 8;
  localparam int CLK_NS = 40;
  localparam int DCLK_TMO_NS = 2560;
  localparam int DCLK_TMO_CYC = DCLK_TMO_NS / CLK_NS;
  localparam int HOST_SETUP_NS = 160;
  localparam int HOST_SETUP_CYC = (HOST_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_STRB_NS = 320;
  localparam int HOST_STRB_CYC = (HOST_STRB_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_GAP_NS = 240;
  localparam int HOST_GAP_CYC = (HOST_GAP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // host controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_ADDR = 8'h01;
  localparam logic [7:0] HREG_WDATA = 8'h02;
  localparam logic [7:0] HREG_CMD = 8'h03;
  localparam logic [7:0] HREG_STAT = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h05;
  localparam int CMD_READ_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
endpackage : hbpw_pkg
`default_nettype wire

// ===== host_bus_ports_watchdog_tb.sv
// testbench joining host end and device end through the bus interface
// assumes the host register map and device register indexes of the package
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module host_bus_ports_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = 8'h01 << hbpw_pkg::WD_START_BIT;
  localparam logic [7:0] SV1 = 8'h01 << hbpw_pkg::WD_SVC1_BIT;
  localparam logic [7:0] SV2 = 8'h01 << hbpw_pkg::WD_SVC2_BIT;
  localparam logic [7:0] EN = 8'h01 << hbpw_pkg::STAT_EN_BIT;
  localparam logic [7:0] OVF = 8'h01 << hbpw_pkg::STAT_OVF_BIT;
  localparam int FS_CYC = 32;
  logic mclk_i, rst_i, fs, dclk, dclk_run, mux, prev_rs, reg_wr, reg_rd, irq, rst_ind;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, cap_addr;
  logic [3:0] port_in, port_out, port_oe;
  logic [1:0] style;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  hbpw_bus_if bus ();
  hbpw_host i_hbpw_host (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .bus(bus));
  hbpw_device #(.WD_PERIOD(16), .RST_IND_LEN(hbpw_pkg::RESET_IND_FS)) i_hbpw_device (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_sync_clock_i(fs), .data_clock_in_i(dclk),
    .port_in_i(port_in), .port_out_o(port_out), .port_oe_o(port_oe), .watchdog_irq_o(irq),
    .reset_indicate_out_o(rst_ind), .bus_style_o(style), .bus(bus));
  hbpw_assertions i_hbpw_assertions (.mclk_i(mclk_i), .rst_i(rst_i),
    .ad_host_oe(bus.ad_host_oe), .ad_dev(bus.ad_dev), .ad_dev_oe(bus.ad_dev_oe), .ale(bus.ale),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .chip_select_one_n(bus.chip_select_one_n));

  // ----------------------------------------------------------------
  // clocks, read address capture and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    dclk = 1'b0;
    forever begin
      repeat (4) @(posedge mclk_i);
      if (dclk_run) dclk <= ~dclk;
    end
  end
  initial begin
    fs = 1'b0;
    forever begin
      repeat (FS_CYC - 4) @(posedge mclk_i);
      fs <= 1'b1;
      repeat (4) @(posedge mclk_i);
      fs <= 1'b0;
    end
  end
  always @(posedge mclk_i) begin
    prev_rs <= bus.read_strobe_n;
    if (prev_rs === 1'b1 && bus.read_strobe_n === 1'b0) cap_addr <= bus.addr;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task hw(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : hw
  task hr(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    @(posedge mclk_i);
    d = reg_rdata;
  endtask : hr
  function automatic logic [7:0] ra(input logic [7:0] i);
    return mux ? {i[6:0], 1'b0} : i;
  endfunction : ra
  task dev_go(input logic [7:0] a, input logic [7:0] d, input logic rdn);
    int i;
    logic [7:0] s;
    hw(hbpw_pkg::HREG_ADDR, a);
    hw(hbpw_pkg::HREG_WDATA, d);
    hw(hbpw_pkg::HREG_CMD, 8'(rdn) << hbpw_pkg::CMD_READ_BIT);
    s = 8'h01;
    for (i = 0; i < 64 && s[hbpw_pkg::STAT_BUSY_BIT] !== 1'b0; i++) hr(hbpw_pkg::HREG_STAT, s);
    `CHK(s[hbpw_pkg::STAT_BUSY_BIT], 1'b0)
  endtask : dev_go
  task dev_wr(input logic [7:0] a, input logic [7:0] d);
    dev_go(ra(a), d, 1'b0);
  endtask : dev_wr
  task dev_chk(input logic [7:0] a, input logic [7:0] e);
    dev_go(a, 8'h00, 1'b1);
    hr(hbpw_pkg::HREG_RDATA, rd);
    `CHK(rd, e)
  endtask : dev_chk
  task fs_wait(input int n);
    repeat (n * FS_CYC) @(posedge mclk_i);
  endtask : fs_wait
  task close_out;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    int i;
    rst_i = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    port_in = 4'ha;
    dclk_run = 1'b1;
    mux = 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    hw(hbpw_pkg::HREG_CTRL, 8'h01);
    repeat (8) @(posedge mclk_i);
    `CHK(style, 2'h1)
    `CHK(port_oe, 4'h0)
    hr(8'h0f, rd);
    `CHK(rd, 8'h00)
    dev_chk(ra(hbpw_pkg::REG_PORT_DIR), 8'h00);
    dev_chk(ra(hbpw_pkg::REG_PORT_VAL), 8'h0a);
    dev_wr(hbpw_pkg::REG_PORT_DIR, 8'h03);
    `CHK(port_oe, 4'h3)
    `CHK(port_out[1:0], 2'h2)
    dev_wr(hbpw_pkg::REG_PORT_VAL, 8'h05);
    `CHK(port_out[1:0], 2'h1)
    dev_chk(ra(hbpw_pkg::REG_PORT_VAL), 8'h09);
    dev_wr(hbpw_pkg::REG_WD_STAT, EN);
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), 8'h00);
    dev_chk(ra(hbpw_pkg::REG_WD_CTRL), 8'h00);
    hw(hbpw_pkg::HREG_CTRL, 8'h00);
    repeat (8) @(posedge mclk_i);
    `CHK(style, 2'h0)
    dev_wr(hbpw_pkg::REG_PORT_DIR, 8'h0c);
    `CHK(port_out[3:2], 2'h2)
    dev_chk(ra(hbpw_pkg::REG_PORT_DIR), 8'h0c);
    port_in <= 4'h5;
    dev_chk(ra(hbpw_pkg::REG_PORT_VAL), 8'h09);
    port_in <= 4'ha;
    fs_wait(20);
    `CHK(irq, 1'b0)
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), 8'h00);
    dev_wr(hbpw_pkg::REG_WD_CTRL, ST);
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), EN);
    dev_wr(hbpw_pkg::REG_WD_CTRL, 8'h00);
    repeat (3) begin
      fs_wait(8);
      dev_wr(hbpw_pkg::REG_WD_CTRL, SV1);
      dev_wr(hbpw_pkg::REG_WD_CTRL, SV2);
    end
    `CHK(irq, 1'b0)
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), EN);
    dclk_run <= 1'b0;
    fs_wait(24);
    `CHK(irq, 1'b0)
    dclk_run <= 1'b1;
    dev_wr(hbpw_pkg::REG_WD_CTRL, SV2);
    dev_wr(hbpw_pkg::REG_WD_CTRL, SV1);
    for (i = 0; i < 640 && rst_ind !== 1'b1; i++) @(posedge mclk_i);
    `CHK(rst_ind, 1'b1)
    `CHK(irq, 1'b1)
    fs_wait(7);
    `CHK(rst_ind, 1'b1)
    fs_wait(2);
    `CHK(rst_ind, 1'b0)
    dev_chk(ra(hbpw_pkg::REG_PORT_DIR), 8'h0c);
    `CHK(port_out[3:2], 2'h2)
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), EN | OVF);
    dev_wr(hbpw_pkg::REG_WD_CTRL, SV1);
    dev_wr(hbpw_pkg::REG_WD_CTRL, SV2);
    dev_wr(hbpw_pkg::REG_WD_STAT, OVF);
    `CHK(irq, 1'b0)
    mux = 1'b1;
    hw(hbpw_pkg::HREG_CTRL, 8'h02);
    dev_go(8'h0a, 8'h00, 1'b1);
    `CHK(style, 2'h2)
    dev_chk(8'h02, 8'h0a);
    dev_chk(8'h03, 8'h0a);
    dev_go(ra(hbpw_pkg::REG_IN_PORT), 8'h00, 1'b1);
    hr(hbpw_pkg::HREG_RDATA, rd);
    `CHK(rd, cap_addr)
    dev_wr(hbpw_pkg::REG_EXT_MODE, 8'h01);
    dev_chk(8'h01, 8'h0a);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    `CHK(port_oe, 4'h0)
    `CHK(irq, 1'b0)
    mux = 1'b0;
    hw(hbpw_pkg::HREG_CTRL, 8'h01);
    repeat (8) @(posedge mclk_i);
    `CHK(style, 2'h1)
    dev_chk(ra(hbpw_pkg::REG_WD_STAT), 8'h00);
    close_out();
  end
endmodule : host_bus_ports_watchdog_tb
`default_nettype wire
